//--- verilog/fac_pkg.sv
package fac_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CONV_TIME_NS  = 500;
    localparam logic [6:0] CONV_CYC = 7'(CONV_TIME_NS / CLK_PERIOD_NS);
    localparam logic [1:0] SMP_TICKS = 2'h2;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TRIG = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_ICLR = 8'h0c;
    localparam logic [7:0] A_IEN  = 8'h10;
    localparam logic [1:0] A_RES_PAGE = 2'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CB_ON   = 15;
    localparam int CB_HALT = 13;
    localparam int CB_AUX  = 12;
    localparam int CB_GSW  = 10;
    localparam int CB_RESULT_FORMAT = 8;
    localparam int CB_EIE  = 7;
    localparam int CB_ORD  = 6;
    localparam int CB_CONT = 4;
    localparam int CB_DIV  = 0;
    localparam logic [15:0] CTRL_RST   = 16'h0003;
    localparam logic [15:0] CTRL_WMASK = 16'hb5f7;
    localparam logic [15:0] CTRL_LOCK  = 16'h11e7;

    // ----------------------------------------------------------------
    // Inputs and pairs
    // ----------------------------------------------------------------
    localparam int NSLOT = 10;
    localparam int NPAIR = 5;
    localparam int NTRIG = 14;
    localparam logic [3:0] AN_EXT_REF = 4'hc;
    localparam logic [3:0] AN_INT_REF = 4'hd;

    typedef enum logic [1:0] {FAC_IDLE, FAC_SAMPLE, FAC_CONV} fac_fsm_type;

    typedef struct packed {
        logic [15:0]                  ctrl;
        logic [19:0]                  tsel;
        logic [NPAIR-1:0]             stat;
        logic [NPAIR-1:0]             ien;
        logic [NSLOT-1:0][15:0]       res;
        logic [NSLOT-1:0]             pend;
        logic [NTRIG-1:0]             tin_prev;
        logic                         gsw_prev;
        fac_fsm_type                  fsm;
        logic [6:0]                   cnt;
        logic [3:0]                   slot;
        logic [3:0]                   an;
        logic [1:0]                   hold;
        logic [1:0][1:0]              dcnt;
        logic [2:0]                   sh;
        logic                         busy;
        logic                         irq;
        logic                         a_wr;
        logic [7:0]                   a_addr;
        logic [31:0]                  rdata;
        logic                         rdy;
    } fac_state_type;

endpackage : fac_pkg

//--- verilog/fac_sched_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fac_sched_if;
    logic [9:0] pend;
    logic       order;
    logic       gnt_vld;
    logic [3:0] gnt_slot;
    logic       aux_sel;
    logic       aux_tick;
    logic [2:0] div;
    logic       adc_tick;

    modport ctl (output pend, order, aux_sel, aux_tick, div,
                 input gnt_vld, gnt_slot, adc_tick);
    modport arb (input pend, order, output gnt_vld, gnt_slot);
    modport clk (input aux_sel, aux_tick, div, output adc_tick);
endinterface : fac_sched_if
`default_nettype wire

//--- verilog/fac_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
module fac_clkdiv
    import fac_pkg::*;
(
    input  wire logic   hclk,
    input  wire logic   hresetn,
    fac_sched_if.clk    sif
);
    typedef struct packed {
        logic [2:0] cnt;
        logic       tick;
    } fac_div_type;

    fac_div_type cs;
    fac_div_type ns;
    logic        src;

    always_comb begin
        ns = cs;
        ns.tick = 1'b0;
        src = sif.aux_sel ? sif.aux_tick : 1'b1;
        if (src) begin
            if (cs.cnt >= sif.div) begin
                ns.cnt = 3'h0;
                ns.tick = 1'b1;
            end else begin
                ns.cnt = cs.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs <= '0;
        end else begin
            cs <= ns;
        end
    end

    assign sif.adc_tick = cs.tick;
endmodule : fac_clkdiv
`default_nettype wire

//--- verilog/fac_arb.sv
`timescale 1ns/1ps
`default_nettype none
module fac_arb
    import fac_pkg::*;
(
    fac_sched_if.arb    sif
);
    logic [3:0] first;

    // Walk pairs downward so the lowest pending pair is kept last
    always_comb begin
        sif.gnt_vld = 1'b0;
        sif.gnt_slot = 4'h0;
        first = 4'h0;
        for (int p = NPAIR - 1; p >= 0; p--) begin
            first = 4'(2 * p) + {3'h0, sif.order};
            if (sif.pend[2*p +: 2] != 2'h0) begin
                sif.gnt_vld = 1'b1;
                sif.gnt_slot = sif.pend[first] ? first : (first ^ 4'h1);
            end
        end
    end
endmodule : fac_arb
`default_nettype wire

//--- verilog/fac_top.sv
`timescale 1ns/1ps
`default_nettype none
module fac_top
    import fac_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic [NTRIG-1:0] trig_in,
    input  wire logic             idle_mode,
    input  wire logic             aux_pll_tick,
    input  wire logic [9:0]       conv_data,
    output logic      [2:0]       sh_sample,
    output logic                  conv_busy,
    output logic      [3:0]       conv_input,
    output logic                  adc_enable,
    output logic                  irq
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic is_ded(input logic [3:0] s);
        is_ded = (s == 4'h0) || (s == 4'h2);
    endfunction : is_ded

    function automatic logic [3:0] slot_an(input logic [3:0] s);
        if (s == 4'h8) begin
            slot_an = AN_EXT_REF;
        end else if (s == 4'h9) begin
            slot_an = AN_INT_REF;
        end else begin
            slot_an = s;
        end
    endfunction : slot_an

    fac_sched_if sif ();

    fac_clkdiv u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sif     (sif.clk)
    );

    fac_arb u_arb (
        .sif (sif.arb)
    );

    fac_state_type    cs;
    fac_state_type    ns;
    logic [15:0]      src_rise;
    logic [NPAIR-1:0] fire;
    logic [NPAIR-1:0] stat_set;
    logic [NPAIR-1:0] stat_clr;
    logic [15:0]      wmask;
    logic [3:0]       sel;
    logic [3:0]       mate;
    logic             run;
    logic             halted;
    logic             done;
    logic             ctrl_wr;
    logic             ap_valid;

    assign sif.pend     = cs.pend;
    assign sif.order    = cs.ctrl[CB_ORD];
    assign sif.aux_sel  = cs.ctrl[CB_AUX];
    assign sif.aux_tick = aux_pll_tick;
    assign sif.div      = cs.ctrl[CB_DIV +: 3];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        ns = cs;
        done = 1'b0;
        ctrl_wr = 1'b0;
        stat_set = '0;
        stat_clr = '0;
        wmask = 16'h0;
        mate = 4'h0;
        sel = 4'h0;
        halted = cs.ctrl[CB_HALT] && idle_mode;
        run = cs.ctrl[CB_ON] && !halted;

        // Code 0 never fires, code 1 is the global soft trigger
        src_rise = {trig_in & ~cs.tin_prev,
                    cs.ctrl[CB_GSW] & ~cs.gsw_prev, 1'b0};
        ns.tin_prev = trig_in;
        ns.gsw_prev = cs.ctrl[CB_GSW];
        for (int p = 0; p < NPAIR; p++) begin
            sel = cs.tsel[4*p +: 4];
            fire[p] = run && src_rise[sel];
        end

        // Dedicated holds, one per pair 0 and 1
        for (int k = 0; k < 2; k++) begin
            if (fire[k]) begin
                ns.hold[k] = 1'b1;
                ns.dcnt[k] = cs.ctrl[CB_CONT] ? 2'h0 : SMP_TICKS;
            end else if (sif.adc_tick && cs.dcnt[k] != 2'h0) begin
                ns.dcnt[k] = cs.dcnt[k] - 2'h1;
            end
        end

        // ------------------------------------------------------------
        // Conversion sequencer
        // ------------------------------------------------------------
        case (cs.fsm)
            FAC_IDLE: begin
                if (run && sif.gnt_vld) begin
                    ns.slot = sif.gnt_slot;
                    ns.an = slot_an(sif.gnt_slot);
                    ns.cnt = 7'h0;
                    ns.fsm = FAC_SAMPLE;
                end
            end
            FAC_SAMPLE: begin
                if (run) begin
                    if (is_ded(cs.slot)) begin
                        if (cs.dcnt[cs.slot[1]] == 2'h0) begin
                            ns.fsm = FAC_CONV;
                            ns.busy = 1'b1;
                        end
                    end else if (sif.adc_tick) begin
                        if (cs.cnt[1:0] == SMP_TICKS - 2'h1) begin
                            ns.fsm = FAC_CONV;
                            ns.busy = 1'b1;
                            ns.cnt = 7'h0;
                        end else begin
                            ns.cnt = cs.cnt + 7'h1;
                        end
                    end
                end
            end
            FAC_CONV: begin
                if (run) begin
                    if (cs.cnt == CONV_CYC - 7'h1) begin
                        done = 1'b1;
                        ns.fsm = FAC_IDLE;
                        ns.busy = 1'b0;
                        ns.pend[cs.slot] = 1'b0;
                        ns.res[cs.slot] = cs.ctrl[CB_RESULT_FORMAT] ?
                            {conv_data, 6'h00} :
                            {6'h00, conv_data};
                        if (is_ded(cs.slot)) begin
                            ns.hold[cs.slot[1]] = 1'b0;
                        end
                        mate = cs.slot ^ 4'h1;
                        if (cs.ctrl[CB_EIE] ? cs.pend[mate]
                                            : !cs.pend[mate]) begin
                            stat_set[cs.slot[3:1]] = 1'b1;
                        end
                    end else begin
                        ns.cnt = cs.cnt + 7'h1;
                    end
                end
            end
            default: begin
                ns.fsm = FAC_IDLE;
            end
        endcase

        // New requests are added after the completion clear
        for (int p = 0; p < NPAIR; p++) begin
            if (fire[p]) begin
                ns.pend[2*p +: 2] = 2'h3;
            end
        end

        // Turning off drops everything in flight
        if (!cs.ctrl[CB_ON]) begin
            ns.fsm = FAC_IDLE;
            ns.busy = 1'b0;
            ns.pend = '0;
            ns.hold = '0;
            ns.dcnt = '0;
        end

        // Dedicated track until held in continuous mode, else sample while dcnt counts down; shared samples in its own phase
        for (int k = 0; k < 2; k++) begin
            ns.sh[k] = cs.ctrl[CB_ON] && (cs.ctrl[CB_CONT] ?
                !ns.hold[k] : ns.dcnt[k] != 2'h0);
        end
        ns.sh[2] = (ns.fsm == FAC_SAMPLE) && !is_ded(ns.slot);

        // ------------------------------------------------------------
        // AHB-Lite slave, zero wait states
        // ------------------------------------------------------------
        ap_valid = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
        ns.rdy = 1'b1;
        ns.a_wr = ap_valid && hwrite;
        ns.a_addr = haddr[7:0];
        ns.rdata = 32'h0;
        if (ap_valid && !hwrite) begin
            case (haddr[7:0])
                A_CTRL: ns.rdata = {16'h0, cs.ctrl};
                A_TRIG: ns.rdata = {12'h0, cs.tsel};
                A_STAT: ns.rdata = {6'h0, cs.pend, 7'h0, cs.busy,
                                    3'h0, cs.stat};
                A_IEN: ns.rdata = {27'h0, cs.ien};
                default: begin
                    if (haddr[7:6] == A_RES_PAGE &&
                        haddr[5:2] < 4'(NSLOT)) begin
                        ns.rdata = {16'h0, cs.res[haddr[5:2]]};
                    end
                end
            endcase
        end
        if (cs.a_wr) begin
            case (cs.a_addr)
                A_CTRL: begin
                    ctrl_wr = 1'b1;
                    wmask = CTRL_WMASK & (cs.ctrl[CB_ON] ? ~CTRL_LOCK
                                                         : 16'hffff);
                    ns.ctrl = (cs.ctrl & ~wmask) |
                              (hwdata[15:0] & wmask);
                end
                A_TRIG: ns.tsel = hwdata[19:0];
                A_ICLR: stat_clr = hwdata[NPAIR-1:0];
                A_IEN: ns.ien = hwdata[NPAIR-1:0];
                default: ns.a_wr = ns.a_wr;
            endcase
        end

        // A completion in the clearing cycle wins over the clear
        ns.stat = (cs.stat & ~stat_clr) | stat_set;
        ns.irq = |(ns.stat & ns.ien);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs <= '0;
            cs.ctrl <= CTRL_RST;
            cs.rdy <= 1'b1;
        end else begin
            cs <= ns;
        end
    end

    assign hrdata     = cs.rdata;
    assign hreadyout  = cs.rdy;
    assign hresp      = 1'b0;
    assign sh_sample  = cs.sh;
    assign conv_busy  = cs.busy;
    assign conv_input = cs.an;
    assign adc_enable = cs.ctrl[CB_ON];
    assign irq        = cs.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_conv_hold;
        cs.busy throughout (##124 1'b1);
    endsequence

    property p_conv_len;
        @(posedge hclk) disable iff (!hresetn || halted)
        $rose(cs.busy) |-> s_conv_hold ##1 !cs.busy;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length is not 500 ns");

    property p_off;
        @(posedge hclk) disable iff (!hresetn)
        !cs.ctrl[CB_ON] |=> !cs.busy && cs.pend == '0;
    endproperty
    a_off: assert property (p_off)
        else $error("converter active while switched off");

    property p_unimpl;
        @(posedge hclk) disable iff (!hresetn)
        (cs.ctrl & ~CTRL_WMASK) == 16'h0;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented control bit set");

    property p_lock;
        @(posedge hclk) disable iff (!hresetn)
        cs.ctrl[CB_ON] && $past(cs.ctrl[CB_ON]) |->
            (cs.ctrl & CTRL_LOCK) == ($past(cs.ctrl) & CTRL_LOCK);
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked control field changed while on");

    property p_gsw_kept;
        @(posedge hclk) disable iff (!hresetn)
        cs.ctrl[CB_GSW] && !ctrl_wr |=> cs.ctrl[CB_GSW];
    endproperty
    a_gsw_kept: assert property (p_gsw_kept)
        else $error("global soft trigger cleared by hardware");

    property p_low_first;
        @(posedge hclk) disable iff (!hresetn)
        cs.fsm == FAC_IDLE && run && cs.pend[1:0] != 2'h0
            |=> cs.slot <= 4'h1;
    endproperty
    a_low_first: assert property (p_low_first)
        else $error("lowest pending input not taken first");

    property p_pend_kept;
        @(posedge hclk) disable iff (!hresetn)
        cs.pend[0] && cs.ctrl[CB_ON] && !(done && cs.slot == 4'h0)
            |=> cs.pend[0];
    endproperty
    a_pend_kept: assert property (p_pend_kept)
        else $error("pending request lost");

    property p_format;
        @(posedge hclk) disable iff (!hresetn)
        done && cs.ctrl[CB_RESULT_FORMAT] |=> cs.res[$past(cs.slot)][5:0] == 6'h0;
    endproperty
    a_format: assert property (p_format)
        else $error("left-justified result has low bits set");

    property p_early;
        @(posedge hclk) disable iff (!hresetn)
        done && cs.ctrl[CB_EIE] && cs.pend[cs.slot ^ 4'h1]
            |=> cs.stat[$past(cs.slot[3:1])];
    endproperty
    a_early: assert property (p_early)
        else $error("early pair-ready not raised");

    property p_halt;
        @(posedge hclk) disable iff (!hresetn)
        halted && cs.fsm == FAC_CONV |=> $stable(cs.cnt);
    endproperty
    a_halt: assert property (p_halt)
        else $error("conversion advanced while halted in idle");
endmodule : fac_top
`default_nettype wire

//--- dv/fac_trig_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Trigger sources: timers and PWM generators on the same clock
// ----------------------------------------------------------------
module fac_trig_model (
    input  wire logic        hclk,
    output logic      [13:0] trig_in
);
    initial trig_in = '0;

    // Only rising edges count, so each pulse drops again; a slow
    // source holds its level for several cycles
    task automatic fire(logic [13:0] m, int dly, int width);
        repeat (dly) @(posedge hclk);
        trig_in <= trig_in | m;
        repeat (width) @(posedge hclk);
        trig_in <= trig_in & ~m;
        @(posedge hclk);
    endtask : fire
endmodule : fac_trig_model
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_total++; $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench
    import fac_pkg::*;
;
    logic        hclk = 0;
    logic        hresetn = 0;
    logic        hsel = 1;
    logic        hwrite = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = HSIZE_WORD;
    logic [2:0]  sh_sample;
    logic        hreadyout;
    logic        hresp;
    logic        idle_mode = 0;
    logic        aux_pll_tick = 0;
    logic        conv_busy;
    logic        adc_enable;
    logic        irq;
    logic [13:0] trig_in;
    logic [9:0]  conv_data = 0;
    logic [3:0]  conv_input;
    logic [9:0]  dtab [16];
    logic [3:0]  seq [$];
    logic        irqs [$];
    logic [15:0] cm;
    logic [15:0] v;
    int          err_total = 0;
    int          n_checks = 0;
    int          len = 0;
    int          since = 9;
    int          done_n = 0;
    int          base = 0;
    int          w = 0;
    logic        halt_on = 0;

    fac_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .trig_in(trig_in),
        .idle_mode(idle_mode), .aux_pll_tick(aux_pll_tick),
        .conv_data(conv_data), .sh_sample(sh_sample),
        .conv_busy(conv_busy), .conv_input(conv_input),
        .adc_enable(adc_enable), .irq(irq));
    fac_trig_model u_trig (.hclk(hclk), .trig_in(trig_in));

    always #2 hclk = ~hclk;

    // ----------------------------------------------------------------
    // Analog side and conversion monitor
    // ----------------------------------------------------------------
    always @(posedge hclk) begin
        conv_data    <= dtab[conv_input];
        aux_pll_tick <= 1'($urandom);
        since        <= since + 1;
        if (since == 3)
            irqs.push_back(irq);
        if (conv_busy && !(idle_mode && halt_on))
            len <= len + 1;
        if (conv_busy && len == 0)
            seq.push_back(conv_input);
        if (!conv_busy && len != 0) begin
            `CHK("busy_len", 500 / 4, len)
            len    <= 0;
            since  <= 1;
            done_n <= done_n + 1;
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    // Waits on hready have no fixed length; a stuck bus ends the run
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        int k;
        k = 0;
        @(posedge hclk);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
        rd = hrdata;
        if (k >= 50) begin
            err_total++;
            final_report();
        end
    endtask : bus

    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1, a, d);
    endtask : wr

    task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
        bus(0, a, 0);
        `CHK(n, e, rd)
        `CHK("hresp", 1'b0, hresp)
    endtask : rchk

    // Locked bits keep their value while the converter was already on
    function automatic logic [15:0] cnext(logic [15:0] o, logic [15:0] n);
        logic [15:0] m;
        m = o[15] ? ~16'h11e7 : 16'hffff;
        return (n & 16'hb5f7 & m) | (o & ~m);
    endfunction : cnext

    // ----------------------------------------------------------------
    // One conversion run: pairs pm, those of pairs 0-3 in f fire first, pair 4 by soft trigger next, rest later
    // ----------------------------------------------------------------
    task automatic conv(string nm, logic [15:0] c, logic [4:0] pm,
                        logic [4:0] f, logic [4:0] ien);
        logic [19:0] ts;
        logic [13:0] m1;
        logic [13:0] m2;
        logic [31:0] x;
        logic [3:0]  e [$];
        int          k;
        int          s;
        ts = '0;
        m1 = '0;
        m2 = '0;
        for (int p = 0; p < 4; p++) begin
            k = p * 3 + $urandom % 3;
            if (pm[p])
                ts[4*p+:4] = 4'(k + 2);
            if (pm[p])
                m1[k] = f[p];
            if (pm[p])
                m2[k] = !f[p];
        end
        ts[19:16] = {3'h0, pm[4]};
        foreach (dtab[i])
            dtab[i] = 10'($urandom);
        wr(A_CTRL, 0);
        wr(A_CTRL, 0);
        wr(A_CTRL, c & 16'h7fff);
        wr(A_TRIG, ts);
        wr(A_IEN, ien);
        wr(A_ICLR, 5'h1f);
        seq.delete();
        irqs.delete();
        base = done_n;
        wr(A_CTRL, c);
        u_trig.fire(m1, 0, 1 + $urandom % 4);
        if (pm[4]) begin
            wr(A_CTRL, c | 16'h0400);
            wr(A_CTRL, c);
        end
        u_trig.fire(m2, 60, 2);
        k = 0;
        while (done_n < base + 2 * $countones(pm) && k++ < 5000)
            @(posedge hclk);
        if (k > 5000) begin
            err_total++;
            final_report();
        end
        for (int p = 0; p < 5; p++) begin
            s = p < 4 ? 2 * p : 12;
            if (pm[p])
                e.push_back(4'(s + c[6]));
            if (pm[p])
                e.push_back(4'(s + !c[6]));
            for (int i = 0; i < 2 && pm[p]; i++) begin
                x = c[8] ? {16'h0, dtab[s+i], 6'h0} : {22'h0, dtab[s+i]};
                rchk("result", 8'(64 + 8 * p + 4 * i), x);
            end
        end
        if (m2 != 0) begin
            e.sort();
            seq.sort();
        end
        `CHK("count", e.size(), seq.size())
        foreach (e[i])
            `CHK("order", e[i], seq[i])
        rchk("status", A_STAT, {27'h0, pm});
        `CHK("sh", (c[4] ? 3'h3 : 3'h0), sh_sample)
        `CHK("irq", |(pm & ien), irq)
        `CHK("early", c[7] & |ien, irqs[0])
        `CHK("late", |ien, irqs[1])
        wr(A_ICLR, 5'h1f);
        rchk("clear", A_STAT, 0);
        `CHK("irq_clr", 1'b0, irq)
        $display("test %s done", nm);
    endtask : conv

    initial begin
        void'($urandom(95012));
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        rchk("ctrl_rst", A_CTRL, 32'h0003);
        rchk("stat_rst", A_STAT, 0);
        cm = 16'h0003;
        for (int i = 0; i < 8; i++) begin
            v = i == 0 ? 16'hffff : 16'($urandom);
            wr(A_CTRL, v);
            cm = cnext(cm, v);
            rchk("ctrl", A_CTRL, cm);
            `CHK("enable", cm[15], adc_enable)
        end
        rchk("unmapped", 8'h30, 0);
        hsize <= 3'h0;
        wr(A_IEN, 32'h1f);
        hsize <= HSIZE_WORD;
        rchk("size", A_IEN, 0);
        $display("test regs done");
        conv("plain", 16'h8003, 5'h15, 5'h15, 5'h1f);
        idle_mode <= 1;
        conv("odd_early", 16'h91c1, 5'h0a, 5'h0a, 5'h1f);
        idle_mode <= 0;
        conv("pending", 16'h8010, 5'h09, 5'h08, 5'h00);
        wr(A_CTRL, 0);
        wr(A_CTRL, 0);
        idle_mode <= 1;
        halt_on = 1;
        wr(A_CTRL, 16'ha003);
        seq.delete();
        u_trig.fire(14'h3fff, 0, 2);
        repeat (300) @(posedge hclk);
        `CHK("halted", 0, seq.size())
        idle_mode <= 0;
        // Trigger again, then freeze the first conversion longer than it lasts
        base = done_n;
        u_trig.fire(14'h3fff, 0, 2);
        repeat (20) @(posedge hclk);
        idle_mode <= 1;
        repeat (150) @(posedge hclk);
        `CHK("frozen_busy", 1'b1, conv_busy)
        `CHK("frozen_input", 4'h0, conv_input)
        idle_mode <= 0;
        while (done_n < base + 4 && w++ < 2000)
            @(posedge hclk);
        if (w > 2000)
            err_total++;
        `CHK("resume_count", 4, seq.size())
        `CHK("resume_order", 4'h6, seq[2])
        $display("test halt done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
